// ==== src/rcls_supervisor.sv ====
// digital loop and reference-loss supervisor of the clock multiplier.
// assumes ref_clk_i and mode pins are asynchronous; fb_tick_i is a one-cycle
// pulse per synthesizer output cycle already on sys_clk_i.
`timescale 1ns/10ps
module rcls_supervisor #(
  parameter int TIMEOUT  = rcls_pkg::TIMEOUT_CYC,
  parameter int SKIP_CYC = rcls_pkg::SKIP_WINDOW_CYC
) (
  input  wire logic        sys_clk_i,                   // oscillator clock
  input  wire logic        srst_i,                      // sync reset
  input  wire logic        ref_clk_i,                   // reference pin
  input  wire logic        fb_tick_i,                   // output clock tick
  input  wire logic [1:0]  mode_sel_i,                  // mode select pins
  input  wire logic [31:0] ratio0_i,                    // set 0 ratio 12.20
  input  wire logic [31:0] ratio1_i,                    // set 1 ratio 12.20
  input  wire logic [31:0] ratio2_i,                    // set 2 ratio 12.20
  input  wire logic [31:0] ratio3_i,                    // set 3 ratio 12.20
  input  wire logic        skip_tolerance_enable_i,     // global skip enable
  input  wire logic        unlocked_output_behavior_i,  // 1 run when unlocked
  output logic [31:0]      divide_value_o,              // synthesizer N
  output logic             locked_o,                    // loop locked
  output logic             wide_bw_o,                   // acquiring bandwidth
  output logic             clk_out_run_o,               // output clock gate
  output logic             timeout_o                    // reference lost
);
  localparam int W = rcls_pkg::CNT_W;
  localparam logic [W-1:0] SKIP_LIM = W'(SKIP_CYC);

  rcls_pkg::rcls_state_type state, next_state;
  logic [2:0]  ref_sync;
  logic [1:0]  mode_m, mode_q;
  logic        ref_edge;
  logic [W-1:0] count, period, prev_per, next_prev_per;
  logic [W-1:0] fb_cnt, next_fb_cnt, tol;
  logic [31:0] div_n, next_div_n, ratio_sel;
  logic [3:0]  good_cnt, next_good_cnt;
  logic signed [33:0] err;
  logic        short_per, long_per, in_gap, err_small, skip_ok;

  function automatic logic [31:0] loop_step(input logic [31:0] n,
                                            input logic signed [33:0] e,
                                            input int sh);
    logic signed [33:0] sum;
    sum = $signed({2'b00, n}) + (e >>> sh);
    return sum[31:0];
  endfunction

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ref_sync <= '0;
      mode_m   <= '0;
      mode_q   <= '0;
    end else begin
      ref_sync <= {ref_sync[1:0], ref_clk_i};
      mode_m   <= mode_sel_i;
      mode_q   <= mode_m;
    end
  end
  assign ref_edge = ref_sync[1] & ~ref_sync[2];

  rcls_period_meter #(.TIMEOUT(TIMEOUT)) u_meter (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .edge_i    (ref_edge),
    .count_o   (count),
    .period_o  (),
    .timeout_o (timeout_o)
  );
  assign period = count;  // period closing at this edge

  always_comb begin
    case (mode_q)
      2'h0:    ratio_sel = ratio0_i;
      2'h1:    ratio_sel = ratio1_i;
      2'h2:    ratio_sel = ratio2_i;
      default: ratio_sel = ratio3_i;
    endcase
  end

  // target minus measured output cycles per reference period, 12.20
  assign err = $signed({2'b00, ratio_sel})
             - $signed({2'b00, fb_cnt[11:0], 20'h0_0000});
  assign err_small = (err < 34'sh0_0010_0000) && (err > -34'sh0_0010_0000);
  assign tol       = prev_per >> 3;
  assign short_per = period < prev_per - tol;
  assign long_per  = period > prev_per + tol;
  assign in_gap    = count > prev_per + tol;
  assign skip_ok   = skip_tolerance_enable_i && period <= SKIP_LIM;

  always_comb begin
    next_state    = state;
    next_div_n    = div_n;
    next_good_cnt = good_cnt;
    next_prev_per = prev_per;
    next_fb_cnt   = fb_tick_i ? fb_cnt + 1'b1 : fb_cnt;
    if (ref_edge) begin
      next_fb_cnt   = fb_tick_i ? W'(1) : '0;
      next_prev_per = period;
    end
    if (timeout_o && state != rcls_pkg::ST_LOST) begin
      next_state    = rcls_pkg::ST_LOST;
      next_good_cnt = '0;
    end else if (ref_edge) begin
      case (state)
        rcls_pkg::ST_LOST: begin
          next_state = rcls_pkg::ST_ACQ;
        end
        rcls_pkg::ST_ACQ: begin
          next_div_n = loop_step(div_n, err, rcls_pkg::WIDE_SHIFT);
          if (err_small) begin
            next_good_cnt = good_cnt + 1'b1;
            if (good_cnt == rcls_pkg::LOCK_RUN - 1'b1) begin
              next_state = rcls_pkg::ST_LOCK;
            end
          end else begin
            next_good_cnt = '0;
          end
        end
        rcls_pkg::ST_LOCK: begin
          if (short_per) begin
            next_state    = rcls_pkg::ST_ACQ;
            next_good_cnt = '0;
          end else if (long_per && skip_ok) begin
            next_prev_per = prev_per;
          end else if (long_per) begin
            next_state    = rcls_pkg::ST_ACQ;
            next_good_cnt = '0;
          end else begin
            next_div_n = loop_step(div_n, err, rcls_pkg::NARROW_SHIFT);
          end
        end
        default: next_state = rcls_pkg::ST_LOST;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state    <= rcls_pkg::ST_LOST;
      div_n    <= rcls_pkg::DIV_RST;
      good_cnt <= '0;
      prev_per <= '0;
      fb_cnt   <= '0;
    end else begin
      state    <= next_state;
      div_n    <= next_div_n;
      good_cnt <= next_good_cnt;
      prev_per <= next_prev_per;
      fb_cnt   <= next_fb_cnt;
    end
  end

  assign divide_value_o = div_n;
  assign locked_o       = state == rcls_pkg::ST_LOCK;
  assign wide_bw_o      = state != rcls_pkg::ST_LOCK;
  // output runs while locked, incl. a clean gap before timeout
  assign clk_out_run_o  = locked_o | unlocked_output_behavior_i;

  sequence seq_lock_edge;
    state == rcls_pkg::ST_LOCK && ref_edge && !timeout_o;
  endsequence

  chk_timeout_unlock: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    timeout_o |=> !locked_o ##1 !locked_o)
    else $error("lock kept after timeout");
  chk_glitch_drop: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    seq_lock_edge and short_per |=> state == rcls_pkg::ST_ACQ)
    else $error("glitch did not drop lock");
  chk_skip_hold: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    seq_lock_edge and long_per && !short_per && skip_ok
    |=> locked_o && $stable(div_n))
    else $error("skip gap lost lock");
  // gap must not become the new period reference
  chk_skip_prev: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    seq_lock_edge and long_per && !short_per && skip_ok
    |=> $stable(prev_per))
    else $error("skip gap replaced period reference");
  chk_gap_reacq: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    seq_lock_edge and long_per && !short_per && !skip_ok
    |=> !locked_o && clk_out_run_o == unlocked_output_behavior_i)
    else $error("late return stayed locked");
  chk_gap_output: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    locked_o && in_gap && !timeout_o && !ref_edge |=> clk_out_run_o)
    else $error("output stopped during gap");
  chk_lost_resume: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    state == rcls_pkg::ST_LOST && ref_edge && !timeout_o
    |=> state == rcls_pkg::ST_ACQ)
    else $error("no re-acquire on return");
  chk_wide_step: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    state == rcls_pkg::ST_ACQ && ref_edge && !timeout_o
    |=> div_n == loop_step($past(div_n), $past(err), rcls_pkg::WIDE_SHIFT))
    else $error("acquire step wrong");
  // steady periods in lock take the small gain step
  chk_narrow_step: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    seq_lock_edge and !short_per && !long_per
    |=> div_n == loop_step($past(div_n), $past(err), rcls_pkg::NARROW_SHIFT))
    else $error("locked step wrong");
  chk_lock_run: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    state == rcls_pkg::ST_ACQ && ref_edge && !timeout_o && err_small
    && good_cnt == rcls_pkg::LOCK_RUN - 1'b1 |=> locked_o)
    else $error("lock not declared after good run");
  chk_mode_global: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    locked_o && mode_q != $past(mode_q) && !ref_edge && !timeout_o
    |=> locked_o)
    else $error("mode change disturbed lock");
endmodule // rcls_supervisor

// ==== src/rcls_period_meter.sv ====
// Notes on behaviour
// - four modal ratio sets; the one indexed by mode select applies.
// - global settings apply in every mode, untouched by mode select.
// - the loop compares output/reference ratio with target, sets N.
// - wide loop bandwidth while acquiring, narrow once locked.
// - with skip tolerance on, lock holds across gaps up to 20 ms.
// - one global bit enables or disables skip tolerance.
// - after a clean loss the output runs for 2^23 oscillator cycles.
// - a glitch or period change on loss drops lock at once; with skip on, a longer period inside the skip window keeps lock.
// - after the 2^23-cycle timeout, unlock and apply unlocked behavior.
// - a reference back after the timeout is re-acquired, then locks.
// - a return after the skip window but in time re-acquires unlocked.
// - skip off, a return inside the skip window re-acquires unlocked.
// - skip on, a return inside the skip window keeps output running.
// - lock within 200 periods below 200 kHz, within 3 ms above.
//
// holds the shared constants and the reference period meter.
// assumes edge_i is a one-cycle pulse already synchronised to sys_clk_i.
`timescale 1ns/10ps
package rcls_pkg;
  localparam int          CNT_W          = 24;
  localparam int          RATIO_W        = 32;
  localparam int          FRAC_W         = 20;
  localparam int          CLK_HZ         = 40_000_000;
  localparam int          SKIP_WINDOW_MS = 20;
  localparam int          SKIP_WINDOW_CYC = SKIP_WINDOW_MS * (CLK_HZ / 1000);
  localparam int          TIMEOUT_CYC    = 8_388_608;
  localparam int          LOCK_MAX_UI    = 200;
  localparam int          WIDE_SHIFT     = 1;
  localparam int          NARROW_SHIFT   = 5;
  localparam logic [3:0]  LOCK_RUN       = 4'h8;
  localparam logic [31:0] DIV_RST        = 32'h0010_0000;
  typedef enum logic [1:0] {ST_ACQ, ST_LOCK, ST_LOST} rcls_state_type;
endpackage

module rcls_period_meter #(
  parameter int TIMEOUT = rcls_pkg::TIMEOUT_CYC
) (
  input  wire logic                       sys_clk_i,  // oscillator clock
  input  wire logic                       srst_i,     // sync reset
  input  wire logic                       edge_i,     // reference edge
  output logic [rcls_pkg::CNT_W-1:0]      count_o,    // cycles since edge
  output logic [rcls_pkg::CNT_W-1:0]      period_o,   // last full period
  output logic                            timeout_o   // counter overflowed
);
  localparam logic [rcls_pkg::CNT_W-1:0] LIMIT = rcls_pkg::CNT_W'(TIMEOUT);
  logic [rcls_pkg::CNT_W-1:0] next_count;
  logic [rcls_pkg::CNT_W-1:0] next_period;
  logic                       next_timeout;

  always_comb begin
    next_count   = count_o;
    next_period  = period_o;
    next_timeout = timeout_o;
    if (edge_i) begin
      next_period  = count_o;
      next_count   = '0;
      next_timeout = 1'b0;
    end else if (count_o == LIMIT - 1'b1) begin
      next_timeout = 1'b1;
    end else if (!timeout_o) begin
      next_count = count_o + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      count_o   <= '0;
      period_o  <= '0;
      timeout_o <= 1'b0;
    end else begin
      count_o   <= next_count;
      period_o  <= next_period;
      timeout_o <= next_timeout;
    end
  end

  chk_meter_restart: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    edge_i |=> count_o == '0 && !timeout_o)
    else $error("meter did not restart on reference edge");
  chk_meter_overflow: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    !edge_i && count_o == LIMIT - 1'b1 |=> timeout_o)
    else $error("meter missed overflow");
endmodule // rcls_period_meter

// ==== bench/rcls_ref_source.sv ====
// reference clock source facing the supervisor's reference pin.
// assumes period_i and mute_i change at the falling edge of sys_clk_i.
`timescale 1ns/10ps
module rcls_ref_source (
  input  wire logic       sys_clk_i,  // bench clock
  input  wire logic [7:0] period_i,   // period in clock cycles
  input  wire logic       mute_i,     // drop pulses from next period
  output logic            ref_clk_o   // reference clock pin
);
  logic [7:0] cnt = 8'h00;
  logic       mute_q = 1'b1;
  // mute sampled per period so gaps are whole periods
  always @(posedge sys_clk_i) begin
    if (cnt >= period_i - 8'h01) begin
      cnt    <= 8'h00;
      mute_q <= mute_i;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
  // slow reference scaled with the shortened timeout
  assign ref_clk_o = ~mute_q & (cnt < (period_i >> 1));
endmodule // rcls_ref_source

// ==== bench/reference_clock_loss_supervisor_tb_top.sv ====
// testbench top for the reference loss supervisor.
// assumes scaled TIMEOUT 64 and SKIP_CYC 32, fb ticks every 4 cycles.
`timescale 1ns/10ps
module reference_clock_loss_supervisor_tb_top;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        fb_tick = 1'b0;
  logic [1:0]  fb_cnt = 2'h0;
  logic [1:0]  mode = 2'h0;
  logic [31:0] ratio [4] = '{default: 32'h0040_0000};
  logic        skip_en = 1'b1;
  logic        uob = 1'b0;
  logic [7:0]  period = 8'h10;
  logic        mute = 1'b1;
  logic        ref_clk;
  logic [31:0] div_val;
  logic        locked, wide_bw, run, tout, saw_unl, saw_stop, saw_to;
  int          fail_count = 0;
  int          checks_done = 0;

  always #12.5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    fb_cnt  <= fb_cnt + 2'h1;
    fb_tick <= (fb_cnt == 2'h3);
  end

  rcls_ref_source u_rcls_ref_source (.sys_clk_i(sys_clk),
    .period_i(period), .mute_i(mute), .ref_clk_o(ref_clk));
  rcls_supervisor #(.TIMEOUT(64), .SKIP_CYC(32)) u_rcls_supervisor (
    .sys_clk_i(sys_clk), .srst_i(srst), .ref_clk_i(ref_clk),
    .fb_tick_i(fb_tick), .mode_sel_i(mode), .ratio0_i(ratio[0]),
    .ratio1_i(ratio[1]), .ratio2_i(ratio[2]), .ratio3_i(ratio[3]),
    .skip_tolerance_enable_i(skip_en), .unlocked_output_behavior_i(uob),
    .divide_value_o(div_val), .locked_o(locked), .wide_bw_o(wide_bw),
    .clk_out_run_o(run), .timeout_o(tout));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic watch(input int n);
    saw_unl = 0; saw_stop = 0; saw_to = 0;
    repeat (n) begin
      @(negedge sys_clk);
      if (locked !== 1'b1) saw_unl = 1;
      if (run !== 1'b1) saw_stop = 1;
      if (tout === 1'b1) saw_to = 1;
    end
  endtask
  task automatic wait_lock;
    int k;
    k = 0;
    while (locked !== 1'b1 && k < 3200) begin
      @(negedge sys_clk);
      k++;
    end
    check(locked, 1'b1);
  endtask
  task automatic do_reset;
    srst = 1'b1; mute = 1'b1;
    cyc(16);
    srst = 1'b0;
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 4; k++)
        ratio[k] = (k == m) ? 32'h0040_0000 : 32'h0090_0000;
      mode = m[1:0]; uob = m[0];
      do_reset;
      check(wide_bw, 1'b1);
      check(run, uob);
      check(div_val, 32'h0010_0000);
      mute = 1'b0;
      wait_lock;
      check(wide_bw, 1'b0);
      check(run, 1'b1);
      mode = m[1:0] ^ 2'h1;
      cyc(8);
      check(locked, 1'b1);
    end
  endtask
  task automatic t_mismatch;
    ratio[2] = 32'h0090_0000; mode = 2'h2;
    do_reset;
    mute = 1'b0;
    cyc(800);
    check(locked, 1'b0);
    check(div_val == 32'h0010_0000, 1'b0);
    ratio[2] = 32'h0040_0000;
    wait_lock;
  endtask
  task automatic t_skip(input logic en);
    skip_en = en; uob = 1'b0;
    mute = 1'b1; cyc(16); mute = 1'b0;
    watch(240);
    check(saw_unl, !en);
    check(saw_stop, !en);
    check(saw_to, 1'b0);
    wait_lock;
  endtask
  task automatic t_long;
    skip_en = 1'b1;
    mute = 1'b1; cyc(32); mute = 1'b0;
    watch(240);
    check(saw_unl, 1'b1);
    check(saw_to, 1'b0);
    wait_lock;
  endtask
  task automatic t_timeout;
    uob = 1'b1; mute = 1'b1;
    cyc(40);
    check(locked, 1'b1);
    check(tout, 1'b0);
    watch(100);
    check(saw_to, 1'b1);
    check(locked, 1'b0);
    check(run, 1'b1);
    uob = 1'b0; cyc(1);
    check(run, 1'b0);
    mute = 1'b0; cyc(60);
    check(locked, 1'b0);
    wait_lock;
    check(tout, 1'b0);
  endtask
  task automatic t_glitch;
    period = 8'h08;
    watch(48);
    check(saw_unl, 1'b1);
    check(saw_to, 1'b0);
    period = 8'h10;
    wait_lock;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    t_modes;
    t_mismatch;
    t_skip(1'b1);
    t_skip(1'b0);
    t_long;
    t_timeout;
    t_glitch;
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    end_of_test;
  end
endmodule // reference_clock_loss_supervisor_tb_top
